// [src/dds_profile_register_bank.sv]
`timescale 1ns/100ps
// Operation
// - Serial word addresses 0x00..0x1B decode to 28 register words.
// - Parallel mode reaches the same storage as 112 byte registers.
// - Field [A:B] spans bit A down to B, bit 0 is LSB.
// - Multi-bit fields are handled as one unsigned binary word.
// - Writes stay buffered until update strobe or profile pin change.
// - Master reset returns every internal register to its default.
// - Oscillator calibration starts on rising trigger bit; must return to zero first.
// - Streaming enable applies parallel input every clock without update strobe.
module dds_profile_register_bank (
    input wire logic clk,
    input wire logic srst,
    input wire dds_regs_pkg::host_req_t req,
    input wire logic io_update,
    input wire logic [2:0] profile_sel,
    input wire logic [31:0] stream_data,
    input wire logic pll_lock,
    output logic [31:0] rdata,
    output logic rvalid,
    output logic addr_err,
    output logic osc_cal_start,
    output logic streaming,
    output dds_regs_pkg::profile_out_t active_profile
);

    // --------------------------------------------------------------------
    // State
    // --------------------------------------------------------------------
    localparam int NB = dds_regs_pkg::BANK_WORDS;

    typedef struct packed {
        logic [NB-1:0][31:0] buf_w;
        logic [NB-1:0][31:0] act_w;
        logic [31:0] ctrl1_buf;
        logic [31:0] ctrl1_act;
        logic [2:0] psel_prev;
        logic lock_s;
        logic [31:0] rdata;
        logic rvalid;
        logic addr_err;
        logic osc_cal;
        dds_regs_pkg::profile_out_t prof;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    // Word index and byte lane from either addressing mode.
    function automatic logic [4:0] word_of(input dds_regs_pkg::host_req_t r);
        return r.par_mode ? r.addr[6:2] : r.addr[4:0];
    endfunction

    function automatic logic [3:0] lanes_of(input dds_regs_pkg::host_req_t r);
        logic [3:0] l;
        l = 4'h0;
        if (r.par_mode) begin
            l[r.addr[1:0]] = 1'b1;
        end else begin
            l = 4'hf;
        end
        return l;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] ln);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (ln[i]) begin
                m[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return m;
    endfunction

    logic [4:0] widx;
    logic [3:0] lanes;
    logic [31:0] wdata_al;
    logic in_range;
    logic commit;

    always_comb begin
        widx = word_of(req);
        lanes = lanes_of(req);
        // Parallel byte data arrives in the low lane and is moved to its lane.
        wdata_al = req.par_mode ? {4{req.wdata[7:0]}} : req.wdata;
        in_range = req.par_mode ? (req.addr <= dds_regs_pkg::LAST_BYTE_ADDR)
                                : (req.addr[6:5] == 2'h0 && req.addr[4:0] <= dds_regs_pkg::LAST_WORD_ADDR);
        commit = io_update || (profile_sel != state_r.psel_prev);
    end

    // --------------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------------
    always_comb begin
        logic [2:0] k;
        logic [31:0] rd;
        logic [31:0] fw;
        logic [31:0] pa;
        k = 3'h0;
        rd = 32'h0000_0000;
        fw = 32'h0000_0000;
        pa = 32'h0000_0000;
        state_nxt = state_r;
        state_nxt.psel_prev = profile_sel;
        state_nxt.lock_s = pll_lock;
        state_nxt.rvalid = 1'b0;
        state_nxt.addr_err = 1'b0;
        if (req.wr && in_range) begin
            if (widx == dds_regs_pkg::ADDR_CTRL1) begin
                state_nxt.ctrl1_buf = merge(state_r.ctrl1_buf, wdata_al, lanes);
            end else if (widx >= dds_regs_pkg::FIRST_BANK_ADDR) begin
                k = 3'(widx - dds_regs_pkg::FIRST_BANK_ADDR);
                if (widx == dds_regs_pkg::ADDR_USER) begin
                    state_nxt.buf_w[k] = merge(state_r.buf_w[k], wdata_al,
                        lanes) & dds_regs_pkg::USER_WRITE_MASK;
                end else begin
                    state_nxt.buf_w[k] = merge(state_r.buf_w[k], wdata_al, lanes);
                end
            end
        end
        if ((req.wr || req.rd) && !in_range) begin
            state_nxt.addr_err = 1'b1;
        end
        if (req.rd && in_range) begin
            if (widx == dds_regs_pkg::ADDR_CTRL1) begin
                rd = state_r.ctrl1_buf;
            end else if (widx >= dds_regs_pkg::FIRST_BANK_ADDR) begin
                k = 3'(widx - dds_regs_pkg::FIRST_BANK_ADDR);
                rd = state_r.buf_w[k];
                if (widx == dds_regs_pkg::ADDR_USER) begin
                    rd[dds_regs_pkg::LOCK_BIT] = state_r.lock_s;
                end
            end
            state_nxt.rdata = req.par_mode ? {24'h00_0000, rd[req.addr[1:0]*8 +: 8]} : rd;
            state_nxt.rvalid = 1'b1;
        end
        if (commit) begin
            state_nxt.act_w = state_nxt.buf_w;
            state_nxt.ctrl1_act = state_nxt.ctrl1_buf;
        end
        // Rising edge of the committed trigger only; holding it high starts nothing more.
        state_nxt.osc_cal = state_nxt.ctrl1_act[dds_regs_pkg::OSC_CAL_BIT]
                            && !state_r.ctrl1_act[dds_regs_pkg::OSC_CAL_BIT];
        // Selected profile; profiles 0..3 live outside this bank and read as zero.
        if (profile_sel[2]) begin
            k = {1'b0, profile_sel[1:0]};
            pa = state_nxt.act_w[2*k];
            fw = (k == 3'h0) ? 32'h0000_0000 : state_nxt.act_w[2*k-1];
        end
        if (state_nxt.ctrl1_act[dds_regs_pkg::STREAM_BIT]) begin
            // Streaming bypasses the update strobe: bus word goes straight out.
            state_nxt.prof.freq = stream_data;
            state_nxt.prof.phase = stream_data[dds_regs_pkg::PHASE_LSB +: dds_regs_pkg::PHASE_W];
            state_nxt.prof.amp = stream_data[dds_regs_pkg::AMP_LSB +: dds_regs_pkg::AMP_W];
        end else begin
            state_nxt.prof.freq = fw;
            state_nxt.prof.phase = pa[dds_regs_pkg::PHASE_LSB +: dds_regs_pkg::PHASE_W];
            state_nxt.prof.amp = pa[dds_regs_pkg::AMP_LSB +: dds_regs_pkg::AMP_W];
        end
    end

    // --------------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= '0;
            for (int i = 0; i < NB - 1; i++) begin
                state_r.buf_w[i] <= dds_regs_pkg::PROFILE_RESET;
                state_r.act_w[i] <= dds_regs_pkg::PROFILE_RESET;
            end
            state_r.buf_w[NB-1] <= dds_regs_pkg::USER_RESET;
            state_r.act_w[NB-1] <= dds_regs_pkg::USER_RESET;
            state_r.ctrl1_buf <= dds_regs_pkg::CTRL1_RESET;
            state_r.ctrl1_act <= dds_regs_pkg::CTRL1_RESET;
            // Track the pins through reset so that release does not look like a profile change.
            state_r.psel_prev <= profile_sel;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign rdata = state_r.rdata;
    assign rvalid = state_r.rvalid;
    assign addr_err = state_r.addr_err;
    assign osc_cal_start = state_r.osc_cal;
    assign streaming = state_r.ctrl1_act[dds_regs_pkg::STREAM_BIT];
    assign active_profile = state_r.prof;

    // --------------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------------
    a_reset_defaults: assert property (@(posedge clk) srst |=> state_r.buf_w[NB-1] == dds_regs_pkg::USER_RESET)
        else $error("user word not at default after reset");
    a_hold_no_commit: assert property (@(posedge clk) disable iff (srst)
        !io_update && profile_sel == state_r.psel_prev |=> $stable(state_r.act_w))
        else $error("active words changed without commit");
    a_commit_copies: assert property (@(posedge clk) disable iff (srst)
        io_update |=> state_r.act_w == state_r.buf_w)
        else $error("update strobe did not copy holding words");
    a_read_one_cycle: assert property (@(posedge clk) disable iff (srst) req.rd && in_range |=> rvalid)
        else $error("read not answered next cycle");
    a_bad_addr_flag: assert property (@(posedge clk) disable iff (srst)
        (req.wr || req.rd) && !in_range |=> addr_err && !rvalid)
        else $error("unmapped address not flagged");
    a_byte_read_narrow: assert property (@(posedge clk) disable iff (srst)
        req.rd && req.par_mode && in_range |=> rdata[31:8] == 24'h00_0000)
        else $error("parallel read wider than a byte");
    a_bad_no_write: assert property (@(posedge clk) disable iff (srst)
        req.wr && !in_range |=> state_r.buf_w == $past(state_r.buf_w))
        else $error("unmapped write changed a holding word");
    a_user_top_ro: assert property (@(posedge clk) disable iff (srst)
        req.wr |=> state_r.buf_w[NB-1][31:24] == 8'h00)
        else $error("user word top byte became writable");
    a_cal_single_pulse: assert property (@(posedge clk) disable iff (srst) osc_cal_start |=> !osc_cal_start)
        else $error("calibration start longer than one cycle");
    a_stream_passes: assert property (@(posedge clk) disable iff (srst)
        streaming && state_nxt.ctrl1_act[dds_regs_pkg::STREAM_BIT] |=> active_profile.freq == $past(stream_data))
        else $error("streamed word not applied");
    a_amp_field: assert property (@(posedge clk) disable iff (srst)
        !state_nxt.ctrl1_act[dds_regs_pkg::STREAM_BIT] && profile_sel == 3'h4
        |=> active_profile.amp == state_r.act_w[0][27:16])
        else $error("amplitude field misplaced");
    c_serial_write: cover property (@(posedge clk) req.wr && !req.par_mode && in_range);
    c_parallel_write: cover property (@(posedge clk) req.wr && req.par_mode && in_range);
    c_profile_commit: cover property (@(posedge clk) profile_sel != state_r.psel_prev);
    c_cal_start: cover property (@(posedge clk) osc_cal_start);
    c_streaming: cover property (@(posedge clk) streaming);

endmodule // dds_profile_register_bank

// [src/dds_regs_pkg.sv]
package dds_regs_pkg;

    // --------------------------------------------------------------------
    // Address map
    // --------------------------------------------------------------------
    localparam int WORD_COUNT = 28;
    localparam int BYTE_COUNT = 112;
    localparam logic [4:0] LAST_WORD_ADDR = 5'h1b;
    localparam logic [6:0] LAST_BYTE_ADDR = 7'h6f;
    localparam logic [4:0] FIRST_BANK_ADDR = 5'h14;
    localparam int BANK_WORDS = 8;
    localparam logic [4:0] ADDR_P4_PA = 5'h14;
    localparam logic [4:0] ADDR_P5_FREQ = 5'h15;
    localparam logic [4:0] ADDR_P5_PA = 5'h16;
    localparam logic [4:0] ADDR_P6_FREQ = 5'h17;
    localparam logic [4:0] ADDR_P6_PA = 5'h18;
    localparam logic [4:0] ADDR_P7_FREQ = 5'h19;
    localparam logic [4:0] ADDR_P7_PA = 5'h1a;
    localparam logic [4:0] ADDR_USER = 5'h1b;
    localparam logic [4:0] ADDR_CTRL1 = 5'h00;

    // --------------------------------------------------------------------
    // Fields and defaults
    // --------------------------------------------------------------------
    localparam int PHASE_LSB = 0;
    localparam int PHASE_W = 16;
    localparam int AMP_LSB = 16;
    localparam int AMP_W = 12;
    localparam int OSC_CAL_BIT = 24;
    localparam int STREAM_BIT = 17;
    localparam int LOCK_BIT = 24;
    localparam logic [31:0] PROFILE_RESET = 32'h0000_0000;
    localparam logic [31:0] USER_RESET = 32'h0000_0800;
    localparam logic [31:0] USER_WRITE_MASK = 32'h00ff_ffff;
    localparam logic [31:0] CTRL1_RESET = 32'h0001_0000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic par_mode;
        logic [6:0] addr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
    } host_req_t;

    typedef struct packed {
        logic [31:0] freq;
        logic [15:0] phase;
        logic [11:0] amp;
    } profile_out_t;

endpackage

// [test/dds_profile_register_bank_test.sv]
`timescale 1ns/100ps
module dds_profile_register_bank_test;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic io_update = 1'b0;
    logic [2:0] profile_sel = 3'h0;
    logic [31:0] stream_data = 32'h0;
    logic pll_lock = 1'b0;
    dds_regs_pkg::host_req_t req;
    logic [31:0] rdata;
    logic rvalid, addr_err, osc_cal_start, streaming;
    dds_regs_pkg::profile_out_t active_profile;
    logic [31:0] hold [8];
    logic [31:0] act [8];
    logic [31:0] q;
    logic e;
    logic [7:0] bad [4] = '{8'h1c, 8'h1f, 8'hf0, 8'hff};
    int errors = 0;
    int checks_done = 0;
    int seed;
    always #2 clk = ~clk;
    dds_profile_register_bank dut_u (.clk(clk), .srst(srst), .req(req), .io_update(io_update),
        .profile_sel(profile_sel), .stream_data(stream_data), .pll_lock(pll_lock), .rdata(rdata),
        .rvalid(rvalid), .addr_err(addr_err), .osc_cal_start(osc_cal_start), .streaming(streaming),
        .active_profile(active_profile));
    host_port_model host_u (.clk(clk), .rvalid(rvalid), .addr_err(addr_err), .rdata(rdata), .req(req));
    task automatic give_verdict();
        $display("errors=%0d checks=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] exp_rd(input logic p, input logic [6:0] a);
        logic [31:0] v;
        int w;
        w = p ? int'(a >> 2) : int'(a);
        v = (w >= 20 && w <= 27) ? hold[w - 20] : 32'h0;
        if (w == 27) v = v | {7'h0, pll_lock, 24'h0};
        return p ? (v >> (8 * a[1:0])) & 32'hff : v;
    endfunction
    task automatic put(input logic p, input logic [6:0] a, input logic [31:0] d);
        int w;
        w = p ? int'(a >> 2) : int'(a);
        host_u.access(1'b1, p, a, d, q, e);
        if (w >= 20 && w <= 27 && p) hold[w - 20][8 * a[1:0] +: 8] = d[7:0];
        if (w >= 20 && w <= 27 && !p) hold[w - 20] = d;
        hold[7] = hold[7] & 32'h00ff_ffff;
    endtask
    task automatic get(input logic p, input logic [6:0] a);
        host_u.access(1'b0, p, a, 32'h0, q, e);
        check(q, exp_rd(p, a));
    endtask
    task automatic words();
        for (int a = 20; a < 28; a++) get(1'b0, 7'(a));
    endtask
    task automatic check_act();
        int s;
        logic [31:0] f, pa;
        repeat (2) @(negedge clk);
        s = int'(profile_sel);
        f = (s >= 5) ? act[2 * s - 9] : 32'h0;
        pa = (s >= 4) ? act[2 * s - 8] : 32'h0;
        check(active_profile, {f, pa[15:0], pa[27:16]});
    endtask
    task automatic commit();
        @(negedge clk);
        io_update = 1'b1;
        @(negedge clk);
        io_update = 1'b0;
        act = hold;
    endtask
    task automatic sel(input logic [2:0] s);
        @(negedge clk);
        profile_sel = s;
        act = hold;
        check_act();
    endtask
    task automatic cal(input logic [31:0] d, input logic exp);
        logic seen;
        host_u.access(1'b1, 1'b0, 7'h00, d, q, e);
        seen = 1'b0;
        commit();
        repeat (3) begin
            if (osc_cal_start === 1'b1) seen = 1'b1;
            @(negedge clk);
        end
        check(seen, exp);
    endtask
    task automatic do_reset();
        @(negedge clk);
        srst = 1'b1;
        repeat (8) @(negedge clk);
        srst = 1'b0;
        foreach (hold[i]) hold[i] = 32'h0;
        hold[7] = 32'h0000_0800;
        act = hold;
    endtask
    initial begin
        #80000;
        errors++;
        give_verdict();
    end
    initial begin
        seed = $urandom(32'h8168);
        do_reset();
        words();
        check(streaming, 1'b0);
        host_u.power_up_cal();
        sel(3'h5);
        for (int a = 20; a < 28; a++) put(1'b0, 7'(a), $urandom());
        check_act();
        words();
        commit();
        check_act();
        foreach (bad[i]) sel(3'(i + 4));
        for (int a = 8'h50; a < 8'h70; a++) put(1'b1, 7'(a), $urandom());
        for (int a = 8'h50; a < 8'h70; a++) get(1'b1, 7'(a));
        words();
        commit();
        check_act();
        foreach (bad[i]) begin
            host_u.access(1'b1, bad[i][7], bad[i][6:0], $urandom(), q, e);
            check(e, 1'b1);
            host_u.access(1'b0, bad[i][7], bad[i][6:0], 32'h0, q, e);
            check(e, 1'b1);
        end
        put(1'b0, 7'h05, $urandom());
        get(1'b0, 7'h05);
        check(e, 1'b0);
        words();
        pll_lock = 1'b1;
        put(1'b0, 7'h1b, 32'hffff_ffff);
        get(1'b0, 7'h1b);
        cal(32'h0100_0000, 1'b1);
        cal(32'h0100_0000, 1'b0);
        cal(32'h0000_0000, 1'b0);
        cal(32'h0100_0000, 1'b1);
        cal(32'h0002_0000, 1'b0);
        check(streaming, 1'b1);
        repeat (4) begin
            stream_data = $urandom();
            repeat (3) @(negedge clk);
            check(active_profile, {stream_data, stream_data[15:0], stream_data[27:16]});
        end
        cal(32'h0000_0000, 1'b0);
        check(streaming, 1'b0);
        do_reset();
        words();
        check_act();
        give_verdict();
    end
endmodule // dds_profile_register_bank_test

// [test/host_port_model.sv]
`timescale 1ns/100ps
module host_port_model #(
    parameter int CONV_CAL_BIT = 0
) (
    input wire logic clk,
    input wire logic rvalid,
    input wire logic addr_err,
    input wire logic [31:0] rdata,
    output dds_regs_pkg::host_req_t req
);
    initial req = '0;
    // Released data is inverted so that a stale value never passes for a fresh one.
    task automatic access(input logic w, input logic p, input logic [6:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(negedge clk);
        req.wr = w;
        req.rd = ~w;
        req.par_mode = p;
        req.addr = a;
        req.wdata = d;
        @(negedge clk);
        req.wr = 1'b0;
        req.rd = 1'b0;
        req.wdata = ~d;
        q = 32'h0;
        e = 1'b0;
        repeat (3) begin
            if (rvalid === 1'b1) q = rdata;
            if (addr_err === 1'b1) e = 1'b1;
            @(negedge clk);
        end
    endtask
    task automatic power_up_cal();
        logic [31:0] q;
        logic e;
        access(1'b1, 1'b0, 7'h00, 32'h1 << CONV_CAL_BIT, q, e);
        access(1'b1, 1'b0, 7'h00, 32'h0, q, e);
    endtask
endmodule // host_port_model
